// file: spm_pkg.sv
/*
 package for the stepper position maintenance block: register offsets,
 reset values, state codes, timing and the bus and pin carriers.
 assumes a 125 MHz clock and a 4-bit word-indexed register port.
*/
package spm_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CORR_STEP_NS = 1000;
	localparam int CORR_STEP_CYC = (CORR_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_STEPS = 3;
	localparam int RATIO_MAX = 9999;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_RATIO = 4'h1;
	localparam logic [3:0] ADDR_STEPS = 4'h2;
	localparam logic [3:0] ADDR_COUNTS = 4'h3;
	localparam logic [3:0] ADDR_CORR = 4'h4;
	localparam logic [3:0] ADDR_STATE = 4'h5;
	localparam logic [3:0] ADDR_ERR = 4'h6;
	localparam logic [3:0] ADDR_STEPCNT = 4'h7;
	localparam logic [3:0] ADDR_FBPOS = 4'h8;

	localparam int CTRL_STOP_BIT = 0;
	localparam logic [1:0] ST_OFF = 2'h0;
	localparam logic [1:0] ST_ON = 2'h1;
	localparam logic [1:0] ST_ERR = 2'h2;

	localparam logic [13:0] RATIO_RST = 14'h0001;
	localparam logic [15:0] STEPS_RST = 16'h0001;
	localparam logic [15:0] COUNTS_RST = 16'h0001;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} spm_bus_t;

	typedef struct packed {
		logic profStep;
		logic profDir;
		logic profBusy;
	} spm_prof_t;

	typedef struct packed {
		logic encA;
		logic encB;
	} spm_enc_t;
endpackage

// file: spm_monitor.sv
/*
 stepper position maintenance monitor for one axis: step gating, step
 count, quadrature feedback count, scaled error, limit check, halt,
 error event and correction move generator, with a plain register port.
 assumes all inputs synchronous to clock and a profiler that pulses
 profStep for one cycle per wanted step.
*/
`timescale 1ns/1ns
module spm_monitor #(
	parameter int W = 32,
	parameter int CORR_CYC = spm_pkg::CORR_STEP_CYC
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire spm_pkg::spm_bus_t bus,
	output logic [31:0] readData,
	input wire spm_pkg::spm_prof_t prof,
	input wire spm_pkg::spm_enc_t enc,
	output logic stepOut,
	output logic dirOut,
	output logic axisHalt,
	output logic errorEvent,
	output logic correctionBusy
);
	generate
		if (W < 16 || W > 40 || CORR_CYC < 1 || CORR_CYC > 255) begin : g_bad
			$error("spm_monitor: unsupported parameter values");
		end
	endgenerate

	typedef struct packed {
		logic [31:0] readData;
		logic stopOnError;
		logic [13:0] ratio;
		logic [15:0] steps;
		logic [15:0] counts;
		logic signed [W-1:0] corr;
		logic [1:0] mstate;
		logic signed [W-1:0] stepCount;
		logic signed [W-1:0] fbPos;
		logic signed [W-1:0] errMag;
		logic [1:0] encPrev;
		logic halted;
		logic corrPending;
		logic corrActive;
		logic corrDone;
		logic signed [W-1:0] corrLeft;
		logic [7:0] corrTimer;
		logic stepOut;
		logic dirOut;
		logic errorEvent;
	} spm_state_t;

	spm_state_t s;
	spm_state_t next_s;

	function automatic logic signed [W-1:0] errOf(input logic signed [W-1:0] st,
		input logic signed [W-1:0] fb, input logic [13:0] ra, input logic [15:0] sp,
		input logic [15:0] cn);
		logic signed [63:0] prod;
		logic signed [63:0] den;
		prod = 64'(fb) * $signed(64'(ra)) * $signed(64'(sp));
		den = $signed(64'((cn == 16'h0000) ? 16'h0001 : cn));
		errOf = W'(64'(st) - prod / den);
	endfunction

	function automatic logic [W-1:0] absOf(input logic signed [W-1:0] v);
		absOf = v[W-1] ? W'(-v) : W'(v);
	endfunction

	localparam int LIMIT_STEPS_C = spm_pkg::LIMIT_STEPS;

	function automatic logic [W-1:0] limOf(input logic [13:0] ra);
		limOf = W'(32'(LIMIT_STEPS_C) * 32'(ra));
	endfunction

	function automatic logic signed [1:0] quadDelta(input logic [1:0] p, input logic [1:0] c);
		unique case ({p, c})
			4'h1, 4'h7, 4'hE, 4'h8: quadDelta = 2'sb01;
			4'h2, 4'hB, 4'hD, 4'h4: quadDelta = -2'sb01;
			default: quadDelta = 2'sb00;
		endcase
	endfunction

	logic [W-1:0] errAbs;
	logic [W-1:0] limit;
	logic stopped;
	logic emit;
	logic emitDir;

	always_comb begin
		next_s = s;
		errAbs = absOf(s.errMag);
		limit = limOf(s.ratio);
		// halted counts as stopped even if the profiler still thinks it runs
		stopped = s.halted || !prof.profBusy;
		emit = 1'b0;
		emitDir = s.dirOut;
		next_s.readData = 32'h0000_0000;
		next_s.errorEvent = 1'b0;

		if (bus.rd) begin
			unique case (bus.addr)
				spm_pkg::ADDR_CTRL: next_s.readData = {31'h0, s.stopOnError};
				spm_pkg::ADDR_RATIO: next_s.readData = 32'(s.ratio);
				spm_pkg::ADDR_STEPS: next_s.readData = 32'(s.steps);
				spm_pkg::ADDR_COUNTS: next_s.readData = 32'(s.counts);
				spm_pkg::ADDR_CORR: next_s.readData = 32'(s.corr);
				spm_pkg::ADDR_STATE: next_s.readData = 32'(s.mstate);
				spm_pkg::ADDR_ERR: next_s.readData = 32'(s.errMag);
				spm_pkg::ADDR_STEPCNT: next_s.readData = 32'(s.stepCount);
				spm_pkg::ADDR_FBPOS: next_s.readData = 32'(s.fbPos);
				default: next_s.readData = 32'h0000_0000;
			endcase
		end

		if (bus.wr) begin
			unique case (bus.addr)
				spm_pkg::ADDR_CTRL: next_s.stopOnError = bus.wdata[spm_pkg::CTRL_STOP_BIT];
				spm_pkg::ADDR_RATIO: begin
					// out-of-range ratios are dropped, the old value stays
					if (bus.wdata != 32'h0 && bus.wdata <= 32'(spm_pkg::RATIO_MAX)) begin
						next_s.ratio = bus.wdata[13:0];
					end
				end
				spm_pkg::ADDR_STEPS: next_s.steps = bus.wdata[15:0];
				spm_pkg::ADDR_COUNTS: begin
					if (bus.wdata[15:0] != 16'h0000) begin
						next_s.counts = bus.wdata[15:0];
					end
				end
				spm_pkg::ADDR_CORR: begin
					next_s.corr = W'(signed'(bus.wdata));
					next_s.corrPending = 1'b1;
				end
				spm_pkg::ADDR_STATE: begin
					if (bus.wdata[31:2] == 30'h0 && bus.wdata[1:0] != 2'h3) begin
						next_s.mstate = bus.wdata[1:0];
						next_s.halted = 1'b0;
						next_s.corrDone = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// correction waits for a stopped axis
		if (s.corrPending && !s.corrActive && stopped) begin
			next_s.corrActive = 1'b1;
			next_s.corrPending = 1'b0;
			next_s.corrLeft = s.corr;
			next_s.corrTimer = 8'h00;
		end

		if (s.corrActive) begin
			if (s.corrLeft == '0) begin
				next_s.corrActive = 1'b0;
				next_s.corrDone = 1'b1;
			end else if (s.corrTimer != 8'h00) begin
				next_s.corrTimer = s.corrTimer - 8'h01;
			end else begin
				emit = 1'b1;
				emitDir = !s.corrLeft[W-1];
				next_s.corrLeft = s.corrLeft[W-1] ? s.corrLeft + W'(1) : s.corrLeft - W'(1);
				next_s.corrTimer = 8'(CORR_CYC - 1);
			end
		end else if (prof.profStep && !s.halted) begin
			emit = 1'b1;
			emitDir = prof.profDir;
		end

		next_s.stepOut = emit;
		next_s.dirOut = emitDir;
		if (emit) begin
			next_s.stepCount = emitDir ? s.stepCount + W'(1) : s.stepCount - W'(1);
		end

		// feedback encoder sits on the main input
		next_s.encPrev = {enc.encA, enc.encB};
		next_s.fbPos = s.fbPos + W'(quadDelta(s.encPrev, {enc.encA, enc.encB}));

		next_s.errMag = errOf(s.stepCount, s.fbPos, s.ratio, s.steps, s.counts);

		// exactly at the limit neither trips nor clears
		if (s.mstate == spm_pkg::ST_ERR && s.corrDone && !s.corrActive && !s.corrPending
			&& errAbs < limit) begin
			next_s.mstate = spm_pkg::ST_ON;
			next_s.corrDone = 1'b0;
			next_s.halted = 1'b0;
		end

		// trip wins over a same-cycle host write
		if (s.mstate == spm_pkg::ST_ON && errAbs > limit) begin
			next_s.mstate = spm_pkg::ST_ERR;
			next_s.errorEvent = 1'b1;
			next_s.corrDone = 1'b0;
			next_s.halted = s.stopOnError;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s <= '0;
			s.ratio <= spm_pkg::RATIO_RST;
			s.steps <= spm_pkg::STEPS_RST;
			s.counts <= spm_pkg::COUNTS_RST;
			s.mstate <= spm_pkg::ST_OFF;
		end else begin
			s <= next_s;
		end
	end

	assign readData = s.readData;
	assign stepOut = s.stepOut;
	assign dirOut = s.dirOut;
	assign axisHalt = s.halted;
	assign errorEvent = s.errorEvent;
	assign correctionBusy = s.corrActive || s.corrPending;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_step_count;
		stepOut |-> s.stepCount == $past(s.stepCount) + (dirOut ? W'(1) : -W'(1));
	endproperty
	a_step_count: assert property (p_step_count) else $error("step count not tracking output");

	property p_err_calc;
		##1 s.errMag == errOf($past(s.stepCount), $past(s.fbPos), $past(s.ratio),
			$past(s.steps), $past(s.counts));
	endproperty
	a_err_calc: assert property (p_err_calc) else $error("error value wrong");

	property p_trip;
		s.mstate == spm_pkg::ST_ON && absOf(s.errMag) > limOf(s.ratio)
			|=> s.mstate == spm_pkg::ST_ERR && errorEvent ##1 !errorEvent;
	endproperty
	a_trip: assert property (p_trip) else $error("limit exceeded without error state");

	property p_halt;
		errorEvent |-> axisHalt == $past(s.stopOnError);
	endproperty
	a_halt: assert property (p_halt) else $error("halt does not follow stop setting");

	property p_halt_blocks;
		axisHalt && !s.corrActive && !s.corrPending && prof.profStep |=> !stepOut;
	endproperty
	a_halt_blocks: assert property (p_halt_blocks) else $error("step passed while halted");

	property p_corr_wait;
		$rose(s.corrActive) |-> $past(stopped);
	endproperty
	a_corr_wait: assert property (p_corr_wait) else $error("correction started while moving");

	sequence s_corr_end;
		s.corrActive && s.corrLeft == '0;
	endsequence
	sequence s_done_idle;
		!s.corrActive && s.corrDone;
	endsequence
	property p_corr_end;
		s_corr_end |=> s_done_idle;
	endproperty
	a_corr_end: assert property (p_corr_end) else $error("correction did not finish");

	property p_clear;
		s.mstate == spm_pkg::ST_ERR && !s.corrActive && s.corrDone && !s.corrPending
			&& absOf(s.errMag) < limOf(s.ratio) |=> s.mstate == spm_pkg::ST_ON;
	endproperty
	a_clear: assert property (p_clear) else $error("error state not cleared");

	property p_read_err;
		bus.rd && bus.addr == spm_pkg::ADDR_ERR |=> readData == 32'($past(s.errMag));
	endproperty
	a_read_err: assert property (p_read_err) else $error("error read mismatch");

	property p_ratio_wr;
		bus.wr && bus.addr == spm_pkg::ADDR_RATIO && bus.wdata == 32'h0000_0100
			|=> s.ratio == 14'h0100;
	endproperty
	a_ratio_wr: assert property (p_ratio_wr) else $error("ratio write lost");
endmodule

// file: spm_drive_model.sv
/*
 behavioural step drive and motor encoder for one axis.
 assumes step pulses of one cycle and x4 quadrature, b leading a when positive.
*/
`timescale 1ns/1ns
module spm_drive_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic stepOut,
	input wire logic dirOut,
	input wire logic lag,
	output spm_pkg::spm_enc_t enc
);
	logic [1:0] phase;
	int debt;
	// friction: while lag is high the rotor falls behind, then catches up
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			phase <= 2'h0;
			debt <= 0;
		end else if (lag) begin
			if (stepOut)
				debt <= debt + 1;
		end else if (stepOut) begin
			phase <= phase + (dirOut ? 2'h1 : 2'h3);
		end else if (debt > 0) begin
			phase <= phase + 2'h1;
			debt <= debt - 1;
		end
	end
	// the only encoder, wired to the feedback input
	// one driver for the whole carrier; b leads a while phase counts up
	assign enc = {phase[1], phase[1] ^ phase[0]};
endmodule

// file: spm_monitor_tb_top.sv
/*
 self-checking bench for the position maintenance monitor.
 assumes the package and the drive model are compiled first.
*/
`timescale 1ns/1ns
module spm_monitor_tb_top;
	logic clock;
	logic reset_n;
	logic lag;
	spm_pkg::spm_bus_t bus;
	spm_pkg::spm_prof_t prof;
	spm_pkg::spm_enc_t enc;
	logic [31:0] readData;
	logic [31:0] rv;
	logic stepOut, dirOut, axisHalt, errorEvent, correctionBusy;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int evtCnt = 0;

	// short correction spacing keeps the run brief
	spm_monitor #(.W(32), .CORR_CYC(2)) dut (.clock(clock), .reset_n(reset_n), .bus(bus), .readData(readData),
		.prof(prof), .enc(enc), .stepOut(stepOut), .dirOut(dirOut), .axisHalt(axisHalt),
		.errorEvent(errorEvent), .correctionBusy(correctionBusy));
	spm_drive_model drive (.clock(clock), .reset_n(reset_n), .stepOut(stepOut), .dirOut(dirOut), .lag(lag),
		.enc(enc));

	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	task tally_and_finish();
		$display("mismatches %0d of %0d comparisons", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (errorEvent === 1'h1)
			evtCnt <= evtCnt + 1;
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			tally_and_finish();
		end
	end

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'h1;
		@(posedge clock);
		bus.wr <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task rdchk(input string name, input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'h1;
		@(posedge clock);
		bus.rd <= 1'h0;
		#1 rv = readData;
		chk(name, exp, rv);
	endtask
	task step(input int n, input logic d);
		repeat (n) begin
			@(posedge clock);
			prof.profStep <= 1'h1;
			prof.profDir <= d;
			@(posedge clock);
			prof.profStep <= 1'h0;
		end
		repeat (6) @(posedge clock);
	endtask

	task t_regs();
		rdchk("ctrl", spm_pkg::ADDR_CTRL, 32'h0);
		rdchk("ratio", spm_pkg::ADDR_RATIO, 32'(spm_pkg::RATIO_RST));
		rdchk("steps", spm_pkg::ADDR_STEPS, 32'(spm_pkg::STEPS_RST));
		rdchk("counts", spm_pkg::ADDR_COUNTS, 32'(spm_pkg::COUNTS_RST));
		rdchk("corr", spm_pkg::ADDR_CORR, 32'h0);
		rdchk("state", spm_pkg::ADDR_STATE, 32'h0);
		rdchk("unmapped", 4'hF, 32'h0);
		wr(spm_pkg::ADDR_ERR, 32'h0000_0055);
		rdchk("err", spm_pkg::ADDR_ERR, 32'h0);
		wr(spm_pkg::ADDR_RATIO, 32'h0);
		wr(spm_pkg::ADDR_RATIO, 32'h0000_2710);
		rdchk("ratio", spm_pkg::ADDR_RATIO, 32'h1);
		wr(spm_pkg::ADDR_RATIO, 32'h0000_270F);
		rdchk("ratio", spm_pkg::ADDR_RATIO, 32'h0000_270F);
		wr(spm_pkg::ADDR_RATIO, 32'h0000_0100);
		rdchk("ratio", spm_pkg::ADDR_RATIO, 32'h0000_0100);
		wr(spm_pkg::ADDR_RATIO, 32'h1);
		wr(spm_pkg::ADDR_STEPS, 32'h0000_00C8);
		rdchk("steps", spm_pkg::ADDR_STEPS, 32'h0000_00C8);
		wr(spm_pkg::ADDR_STEPS, 32'h1);
		wr(spm_pkg::ADDR_COUNTS, 32'h0);
		rdchk("counts", spm_pkg::ADDR_COUNTS, 32'h1);
		wr(spm_pkg::ADDR_STATE, 32'h3);
		rdchk("state", spm_pkg::ADDR_STATE, 32'h0);
	endtask

	task t_track();
		wr(spm_pkg::ADDR_STATE, 32'(spm_pkg::ST_ON));
		step(5, 1'h1);
		step(2, 1'h0);
		chk("dirOut", 32'h0, {31'h0, dirOut});
		rdchk("stepcnt", spm_pkg::ADDR_STEPCNT, 32'h3);
		rdchk("fbpos", spm_pkg::ADDR_FBPOS, 32'h3);
		rdchk("err", spm_pkg::ADDR_ERR, 32'h0);
	endtask

	task t_trip_run();
		lag <= 1'h1;
		step(3, 1'h1);
		// equal to the limit is not beyond it
		rdchk("err", spm_pkg::ADDR_ERR, 32'h3);
		rdchk("state", spm_pkg::ADDR_STATE, 32'(spm_pkg::ST_ON));
		step(1, 1'h1);
		rdchk("state", spm_pkg::ADDR_STATE, 32'(spm_pkg::ST_ERR));
		chk("events", 32'h1, 32'(evtCnt));
		chk("axisHalt", 32'h0, {31'h0, axisHalt});
		step(1, 1'h1);
		rdchk("stepcnt", spm_pkg::ADDR_STEPCNT, 32'h8);
		lag <= 1'h0;
		prof.profBusy <= 1'h1;
		wr(spm_pkg::ADDR_CORR, 32'h2);
		repeat (12) @(posedge clock);
		rdchk("stepcnt", spm_pkg::ADDR_STEPCNT, 32'h8);
		prof.profBusy <= 1'h0;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 60 && correctionBusy !== 1'h0; i++)
			@(posedge clock);
		repeat (4) @(posedge clock);
		chk("corrBusy", 32'h0, {31'h0, correctionBusy});
		rdchk("stepcnt", spm_pkg::ADDR_STEPCNT, 32'hA);
		rdchk("state", spm_pkg::ADDR_STATE, 32'(spm_pkg::ST_ON));
	endtask

	task t_trip_halt();
		wr(spm_pkg::ADDR_CTRL, 32'h1);
		lag <= 1'h1;
		step(4, 1'h1);
		chk("axisHalt", 32'h1, {31'h0, axisHalt});
		chk("events", 32'h2, 32'(evtCnt));
		step(1, 1'h1);
		rdchk("stepcnt", spm_pkg::ADDR_STEPCNT, 32'hE);
		lag <= 1'h0;
		// let the rotor catch up first, else re-enabling trips again at once
		repeat (8) @(posedge clock);
		rdchk("err", spm_pkg::ADDR_ERR, 32'h0);
		wr(spm_pkg::ADDR_STATE, 32'(spm_pkg::ST_ON));
		repeat (2) @(posedge clock);
		chk("axisHalt", 32'h0, {31'h0, axisHalt});
		chk("events", 32'h2, 32'(evtCnt));
	endtask

	initial begin
		reset_n = 1'h0;
		lag = 1'h0;
		bus = '0;
		prof = '0;
		repeat (2) @(posedge clock);
		reset_n <= 1'h1;
		t_regs();
		t_track();
		t_trip_run();
		t_trip_halt();
		tally_and_finish();
	end
endmodule
